/* File: logic/spm_pkg.sv */
`default_nettype none
package spm_pkg;
  // Register offsets in the configuration function
  localparam logic [7:0] SPM_OFF_DATA2 = 8'h66;
  localparam logic [7:0] SPM_OFF_DATA3 = 8'h67;
  localparam logic [7:0] SPM_OFF_PTR23 = 8'h69;
  localparam logic [7:0] SPM_OFF_MISC0 = 8'h6a;
  localparam logic [7:0] SPM_OFF_MISC1 = 8'h6c;
  localparam logic [7:0] SPM_OFF_TS1 = 8'h78;
  localparam logic [7:0] SPM_OFF_TS2 = 8'h79;
  localparam logic [7:0] SPM_OFF_OOB = 8'h7d;
  localparam logic [7:0] SPM_OFF_SWPM = 8'h80;
  localparam logic [7:0] SPM_OFF_HW0 = 8'h81;
  localparam logic [7:0] SPM_OFF_HW1 = 8'h8c;
  // Reset values and writable masks
  localparam logic [7:0] SPM_RST_ZERO = 8'h00;
  localparam logic [7:0] SPM_RST_MISC = 8'h20;
  localparam logic [7:0] SPM_MASK_MISC = 8'h38;
  localparam logic [7:0] SPM_MASK_SW = 8'h0f;
  localparam logic [7:0] SPM_MASK_HW1 = 8'h1f;
  // Field positions
  localparam int SPM_PTR3_LO = 4;
  localparam int SPM_PTR2_LO = 0;
  localparam int SPM_EQ_LO = 4;
  localparam int SPM_OOB_PAT = 3;
  localparam int SPM_PMP = 7;
  localparam int SPM_INACT_EN = 7;
  localparam int SPM_LP0 = 6;
  localparam int SPM_LP1 = 5;
  localparam int SPM_TEN_LO = 3;
  localparam int SPM_PER_LO = 0;
  localparam logic [1:0] SPM_WIN2_SEL = 2'h2;
  localparam logic [1:0] SPM_WIN3_SEL = 2'h3;
  // Power codes and timer enable codes
  localparam logic [3:0] SPM_CODE_PARTIAL = 4'h1;
  localparam logic [3:0] SPM_CODE_SLUMBER = 4'h2;
  localparam logic [1:0] SPM_TEN_PART_ONLY = 2'h1;
  localparam logic [1:0] SPM_TEN_SLUM_ONLY = 2'h2;
  localparam logic [1:0] SPM_TEN_NONE = 2'h3;
  localparam logic [6:0] SPM_PART_MULT = 7'h02;
  localparam logic [6:0] SPM_SLUM_MULT = 7'h0a;
  // Idle timer unit t = 0.425 s
  localparam int SPM_UNIT_US = 425000;
  localparam int SPM_CLK_NS = 10;
  localparam int SPM_UNIT_CYC_DEF = SPM_UNIT_US * 1000 / SPM_CLK_NS;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } spm_cfg_req_t;

  typedef struct packed {
    logic dma_rd_dev;
    logic dma_wr_dev;
    logic sg_active;
    logic irq;
    logic fifo_empty;
    logic pmp_err;
    logic port_sel;
    logic pio_tx;
    logic pio_rx;
    logic dma_tx;
    logic dma_rx;
  } spm_tp_stat_t;

  localparam spm_tp_stat_t SPM_TP_RST = '{fifo_empty: 1'b1, default: 1'b0};

  typedef struct packed {
    logic [1:0] partial;
    logic [1:0] slumber;
    logic [1:0] wake;
  } spm_pm_req_t;

  typedef enum logic [3:0] {
    SPM_ACT = 4'h1,
    SPM_PART = 4'h2,
    SPM_EXIT = 4'h4,
    SPM_SLUM = 4'h8
  } spm_lp_t;
endpackage
`default_nettype wire

/* File: logic/spm_regs.sv */
`default_nettype none
module spm_regs import spm_pkg::*; #(
  parameter int UNIT_CYC = SPM_UNIT_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire spm_cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  output logic [5:0] phy_addr,
  output logic phy_wr,
  output logic phy_rd,
  output logic [7:0] phy_wdata,
  input wire logic [7:0] phy_rdata,
  input wire spm_tp_stat_t tp_stat,
  input wire logic [1:0] cominit_seen,
  input wire logic [1:0] comwake_seen,
  input wire logic [1:0] oob_seq_end,
  output logic [1:0][1:0] eq_duration,
  output logic [1:0] oob_pattern_d243,
  output spm_pm_req_t pm_req,
  output logic [1:0][3:0] spm_field
);
  localparam int CW = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;
  localparam logic [CW-1:0] UNIT_LAST = CW'(UNIT_CYC - 1);

  // Refuse a timer unit the counter cannot hold
  if (UNIT_CYC < 1) begin : g_bad_unit
    $error("UNIT_CYC must be at least one");
  end

  // ****************************************************
  // Register decode
  // ****************************************************
  logic [7:0] ptr_reg;
  logic [7:0] misc_reg [2];
  logic [7:0] sw_reg;
  logic [7:0] hw0_reg;
  logic [7:0] hw1_reg;
  logic pmp_reg;
  logic [3:0] oob_reg;
  spm_tp_stat_t tp_q;
  logic port_q;
  logic wr_ptr, wr_m0, wr_m1, wr_ts2, wr_sw, wr_hw0, wr_hw1, wr_d2, wr_d3;
  logic rd_win;

  // Write strobes, gated by the clock enable
  always_comb begin
    wr_ptr = 1'b0;
    wr_m0 = 1'b0;
    wr_m1 = 1'b0;
    wr_ts2 = 1'b0;
    wr_sw = 1'b0;
    wr_hw0 = 1'b0;
    wr_hw1 = 1'b0;
    wr_d2 = 1'b0;
    wr_d3 = 1'b0;
    if (cfg_req.wr && clk_en) begin
      if (cfg_req.addr == SPM_OFF_PTR23) begin
        wr_ptr = 1'b1;
      end else if (cfg_req.addr == SPM_OFF_MISC0) begin
        wr_m0 = 1'b1;
      end else if (cfg_req.addr == SPM_OFF_MISC1) begin
        wr_m1 = 1'b1;
      end else if (cfg_req.addr == SPM_OFF_TS2) begin
        wr_ts2 = 1'b1;
      end else if (cfg_req.addr == SPM_OFF_SWPM) begin
        wr_sw = 1'b1;
      end else if (cfg_req.addr == SPM_OFF_HW0) begin
        wr_hw0 = 1'b1;
      end else if (cfg_req.addr == SPM_OFF_HW1) begin
        wr_hw1 = 1'b1;
      end else if (cfg_req.addr == SPM_OFF_DATA2) begin
        wr_d2 = 1'b1;
      end else if (cfg_req.addr == SPM_OFF_DATA3) begin
        wr_d3 = 1'b1;
      end
    end
  end

  // ****************************************************
  // Embedded PHY data windows
  // ****************************************************
  // Window 2 reaches 4n+2, window 3 reaches 4n+3
  always_comb begin
    phy_addr = {ptr_reg[SPM_PTR2_LO +: 4], SPM_WIN2_SEL};
    if (cfg_req.addr == SPM_OFF_DATA3) begin
      phy_addr = {ptr_reg[SPM_PTR3_LO +: 4], SPM_WIN3_SEL};
    end
    rd_win = (cfg_req.addr == SPM_OFF_DATA2) || (cfg_req.addr == SPM_OFF_DATA3);
    phy_wr = wr_d2 | wr_d3;
    phy_rd = cfg_req.rd & clk_en & rd_win;
    phy_wdata = cfg_req.wdata;
  end

  // Pointer pair register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= SPM_RST_ZERO;
    end else if (wr_ptr) begin
      ptr_reg <= cfg_req.wdata;
    end
  end

  // ****************************************************
  // Per-port PHY miscellaneous control
  // ****************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      misc_reg[0] <= SPM_RST_MISC;
      misc_reg[1] <= SPM_RST_MISC;
    end else begin
      if (wr_m0) begin
        misc_reg[0] <= cfg_req.wdata & SPM_MASK_MISC;
      end
      if (wr_m1) begin
        misc_reg[1] <= cfg_req.wdata & SPM_MASK_MISC;
      end
    end
  end

  // Drive the PHY settings straight from the registers
  for (genvar p = 0; p < 2; p++) begin : g_misc
    assign eq_duration[p] = misc_reg[p][SPM_EQ_LO +: 2];
    assign oob_pattern_d243[p] = misc_reg[p][SPM_OOB_PAT];
  end

  // ****************************************************
  // Transport and OOB status
  // ****************************************************
  // Snapshot of transport state; buffer reads empty from reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tp_q <= SPM_TP_RST;
      port_q <= 1'b0;
    end else if (clk_en) begin
      tp_q <= tp_stat;
      port_q <= tp_q.port_sel;
    end
  end

  // Sticky error; a new error beats a same-cycle clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pmp_reg <= 1'b0;
    end else if (clk_en) begin
      pmp_reg <= tp_stat.pmp_err | (pmp_reg & ~(wr_ts2 & cfg_req.wdata[SPM_PMP]));
    end
  end

  // OOB flags: bit order port1 init, port1 wake, port0 init, port0 wake
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oob_reg <= 4'h0;
    end else if (clk_en) begin
      for (int p = 0; p < 2; p++) begin
        oob_reg[2*p] <= comwake_seen[p] | (oob_reg[2*p] & ~oob_seq_end[p]);
        oob_reg[2*p+1] <= cominit_seen[p] | (oob_reg[2*p+1] & ~oob_seq_end[p]);
      end
    end
  end

  // ****************************************************
  // Power management control registers
  // ****************************************************
  logic [3:0] sw_rise;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sw_reg <= SPM_RST_ZERO;
      hw0_reg <= SPM_RST_ZERO;
      hw1_reg <= SPM_RST_ZERO;
    end else begin
      if (wr_sw) begin
        sw_reg <= cfg_req.wdata & SPM_MASK_SW;
      end
      if (wr_hw0) begin
        hw0_reg <= cfg_req.wdata;
      end
      if (wr_hw1) begin
        hw1_reg <= cfg_req.wdata & SPM_MASK_HW1;
      end
    end
  end

  // Only a new one fires; rewriting a held one is silent
  assign sw_rise = wr_sw ? (cfg_req.wdata[3:0] & ~sw_reg[3:0]) : 4'h0;

  // ****************************************************
  // Idle timers and per-port low-power sequencing
  // ****************************************************
  logic busy;
  logic [1:0] act, part_hit, slum_hit, part_en, slum_en;
  logic [1:0] t_part, t_slum, t_wake;
  logic [6:0] idle_u [2];
  logic [6:0] t_units [2];
  logic [6:0] thr_p [2];
  logic [6:0] thr_s [2];
  logic [CW-1:0] unit_cnt [2];
  logic [7:0] tcfg [2];
  spm_lp_t st [2];

  assign busy = tp_q.dma_rd_dev | tp_q.dma_wr_dev | tp_q.sg_active |
                tp_q.pio_tx | tp_q.pio_rx | tp_q.dma_tx | tp_q.dma_rx;
  assign tcfg[0] = hw0_reg;
  assign tcfg[1] = hw1_reg;

  for (genvar p = 0; p < 2; p++) begin : g_tmr
    logic tick;

    // Work on this port counts as activity
    assign act[p] = busy && (tp_q.port_sel == 1'(p));
    assign t_units[p] = 7'(tcfg[p][SPM_PER_LO +: 3]) + 7'h01;
    assign thr_p[p] = 7'(t_units[p] * SPM_PART_MULT);
    assign thr_s[p] = 7'(t_units[p] * SPM_SLUM_MULT);
    assign part_en[p] = (tcfg[p][SPM_TEN_LO +: 2] != SPM_TEN_SLUM_ONLY) &&
                        (tcfg[p][SPM_TEN_LO +: 2] != SPM_TEN_NONE);
    assign slum_en[p] = (tcfg[p][SPM_TEN_LO +: 2] != SPM_TEN_PART_ONLY) &&
                        (tcfg[p][SPM_TEN_LO +: 2] != SPM_TEN_NONE);
    assign tick = (unit_cnt[p] == UNIT_LAST);
    assign part_hit[p] = tick && !act[p] && (idle_u[p] + 7'h01 == thr_p[p]);
    assign slum_hit[p] = tick && !act[p] && (idle_u[p] + 7'h01 == thr_s[p]);

    // Idle time in units of t, saturating; activity restarts it
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        unit_cnt[p] <= '0;
        idle_u[p] <= 7'h00;
      end else if (clk_en) begin
        if (act[p]) begin
          unit_cnt[p] <= '0;
          idle_u[p] <= 7'h00;
        end else if (tick) begin
          unit_cnt[p] <= '0;
          if (idle_u[p] != 7'h7f) begin
            idle_u[p] <= idle_u[p] + 7'h01;
          end
        end else begin
          unit_cnt[p] <= unit_cnt[p] + CW'(1);
        end
      end
    end

    // Timer-driven power state of this port
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        st[p] <= SPM_ACT;
      end else if (clk_en) begin
        case (st[p])
          SPM_ACT: begin
            if (part_hit[p] && part_en[p]) begin
              st[p] <= SPM_PART;
            end else if (slum_hit[p] && slum_en[p]) begin
              st[p] <= SPM_SLUM;
            end
          end
          SPM_PART: begin
            if (act[p]) begin
              st[p] <= SPM_ACT;
            end else if (slum_hit[p] && slum_en[p]) begin
              st[p] <= SPM_EXIT;
            end
          end
          SPM_EXIT: begin
            st[p] <= SPM_SLUM;
          end
          SPM_SLUM: begin
            if (act[p]) begin
              st[p] <= SPM_ACT;
            end
          end
          default: begin
            st[p] <= SPM_ACT;
          end
        endcase
      end
    end

    // Requests issued by the timer path
    assign t_part[p] = (st[p] == SPM_ACT) && part_hit[p] && part_en[p];
    assign t_wake[p] = (st[p] == SPM_PART) && slum_hit[p] && slum_en[p];
    assign t_slum[p] = (st[p] == SPM_EXIT) ||
                       ((st[p] == SPM_ACT) && !(part_hit[p] && part_en[p]) &&
                        slum_hit[p] && slum_en[p]);
  end

  // ****************************************************
  // Request merge toward the PHY
  // ****************************************************
  logic switch_evt;
  logic old_lp_slum;
  logic [1:0] rq_part, rq_slum;

  // Port switch puts the port just left into its chosen mode at once
  assign switch_evt = hw0_reg[SPM_INACT_EN] && (tp_q.port_sel != port_q);
  assign old_lp_slum = port_q ? hw0_reg[SPM_LP1] : hw0_reg[SPM_LP0];

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      rq_part[p] = sw_rise[2*p] | t_part[p] |
                   (switch_evt && (port_q == 1'(p)) && !old_lp_slum);
      rq_slum[p] = sw_rise[2*p+1] | t_slum[p] |
                   (switch_evt && (port_q == 1'(p)) && old_lp_slum);
    end
  end

  // One-cycle request pulses plus the last SPM code per port
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pm_req <= '0;
      spm_field <= '0;
    end else if (clk_en) begin
      pm_req.partial <= rq_part & ~rq_slum;
      pm_req.slumber <= rq_slum;
      pm_req.wake <= t_wake;
      for (int p = 0; p < 2; p++) begin
        if (rq_slum[p]) begin
          spm_field[p] <= SPM_CODE_SLUMBER;
        end else if (rq_part[p]) begin
          spm_field[p] <= SPM_CODE_PARTIAL;
        end
      end
    end
  end

  // ****************************************************
  // Read data
  // ****************************************************
  // Unmapped offsets read as zero; reserved bits read as zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 8'h00;
    end else if (clk_en && cfg_req.rd) begin
      if (rd_win) begin
        cfg_rdata <= phy_rdata;
      end else if (cfg_req.addr == SPM_OFF_PTR23) begin
        cfg_rdata <= ptr_reg;
      end else if (cfg_req.addr == SPM_OFF_MISC0) begin
        cfg_rdata <= misc_reg[0];
      end else if (cfg_req.addr == SPM_OFF_MISC1) begin
        cfg_rdata <= misc_reg[1];
      end else if (cfg_req.addr == SPM_OFF_TS1) begin
        cfg_rdata <= {3'h0, tp_q.dma_rd_dev, tp_q.dma_wr_dev, tp_q.sg_active,
                      tp_q.irq, tp_q.fifo_empty};
      end else if (cfg_req.addr == SPM_OFF_TS2) begin
        cfg_rdata <= {pmp_reg, 2'h0, tp_q.port_sel, tp_q.pio_tx, tp_q.pio_rx,
                      tp_q.dma_tx, tp_q.dma_rx};
      end else if (cfg_req.addr == SPM_OFF_OOB) begin
        cfg_rdata <= {4'h0, oob_reg};
      end else if (cfg_req.addr == SPM_OFF_SWPM) begin
        cfg_rdata <= sw_reg;
      end else if (cfg_req.addr == SPM_OFF_HW0) begin
        cfg_rdata <= hw0_reg;
      end else if (cfg_req.addr == SPM_OFF_HW1) begin
        cfg_rdata <= hw1_reg;
      end else begin
        cfg_rdata <= 8'h00;
      end
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wake0;
    pm_req.wake[0] && clk_en;
  endsequence

  sequence s_slum0;
    pm_req.slumber[0] ##0 (spm_field[0] == SPM_CODE_SLUMBER);
  endsequence

  a_win3_addr: assert property (wr_d3 |-> phy_wr && phy_addr[1:0] == SPM_WIN3_SEL &&
    phy_addr[5:2] == ptr_reg[SPM_PTR3_LO +: 4])
    else $error("window 3 address wrong");
  a_win2_addr: assert property (wr_d2 |-> phy_wr && phy_addr[1:0] == SPM_WIN2_SEL &&
    phy_addr[5:2] == ptr_reg[SPM_PTR2_LO +: 4])
    else $error("window 2 address wrong");
  a_fifo_empty_rst: assert property ($rose(rst_n) |-> tp_q.fifo_empty)
    else $error("buffer empty not set after reset");
  a_irq_track: assert property (clk_en |=> tp_q.irq == $past(tp_stat.irq))
    else $error("interrupt status lags");
  a_pmp_sticky: assert property (pmp_reg && !(wr_ts2 && cfg_req.wdata[SPM_PMP])
    |=> pmp_reg)
    else $error("error flag lost without clear");
  a_oob_set: assert property (clk_en && cominit_seen[0] |=> oob_reg[1])
    else $error("COMINIT flag not set");
  a_oob_hold: assert property (oob_reg[0] && !(clk_en && oob_seq_end[0])
    |=> oob_reg[0])
    else $error("COMWAKE flag dropped early");
  a_sw_partial: assert property (wr_sw && cfg_req.wdata[0] && !cfg_req.wdata[1] &&
    !sw_reg[0] |=> pm_req.partial[0] && spm_field[0] == SPM_CODE_PARTIAL)
    else $error("software partial not issued");
  a_sw_no_repeat: assert property (wr_sw && cfg_req.wdata[1] && sw_reg[1] &&
    !t_slum[0] && !switch_evt |=> !pm_req.slumber[0])
    else $error("held request repeated");
  a_switch_slum: assert property (clk_en && switch_evt && !port_q &&
    hw0_reg[SPM_LP0] |=> pm_req.slumber[0])
    else $error("inactive port not put to slumber");
  a_part_timer: assert property (clk_en && st[0] == SPM_ACT && part_hit[0] &&
    part_en[0] |=> pm_req.partial[0] ##0 st[0] == SPM_PART)
    else $error("timer partial missing");
  a_thresh_ratio: assert property (slum_hit[0] |-> idle_u[0] ==
    7'((7'(hw0_reg[SPM_PER_LO +: 3]) + 7'h01) * SPM_SLUM_MULT - 7'h01))
    else $error("slumber threshold not ten periods");
  a_wake_slum: assert property (s_wake0 |=> s_slum0)
    else $error("slumber not after partial exit");
  a_idle_restart: assert property (clk_en && act[0] |=> idle_u[0] == 7'h00)
    else $error("idle count not restarted");
endmodule
`default_nettype wire

/* File: tb/spm_dev_model.sv */
`default_nettype none
module spm_dev_model import spm_pkg::*; (
  input wire logic mclk,
  input wire logic [5:0] phy_addr,
  input wire logic phy_wr,
  input wire logic phy_rd,
  input wire logic [7:0] phy_wdata,
  output logic [7:0] phy_rdata,
  input wire logic oob_go,
  input wire logic [1:0] oob_sel,
  output logic [1:0] cominit_seen,
  output logic [1:0] comwake_seen,
  output logic [1:0] oob_seq_end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [64];
  logic [7:0] last_q = 8'h5a;
  int cnt = 0;
  // ****************
  // Far-side PHY registers and OOB
  // ****************
  // Idle read data toggles each cycle so a stale byte never looks valid
  assign phy_rdata = phy_rd ? mem[phy_addr] : ~last_q;
  always @(posedge mclk) begin
    last_q <= phy_rdata;
    if (phy_wr) mem[phy_addr] <= phy_wdata;
  end
  initial {cominit_seen, comwake_seen, oob_seq_end} = 6'h00;
  // Burst sequence: first burst and gap at count 6, sequence end at 20
  always @(posedge mclk) begin
    cominit_seen <= 2'h0;
    comwake_seen <= 2'h0;
    oob_seq_end <= 2'h0;
    cnt <= oob_go ? 1 : (cnt == 0 || cnt == 20) ? 0 : cnt + 1;
    if (cnt == 6 && oob_sel[0]) cominit_seen[oob_sel[1]] <= 1'b1;
    if (cnt == 6 && !oob_sel[0]) comwake_seen[oob_sel[1]] <= 1'b1;
    if (cnt == 20) oob_seq_end[oob_sel[1]] <= 1'b1;
  end
endmodule
`default_nettype wire

/* File: tb/spm_regs_tb_top.sv */
`default_nettype none
module spm_regs_tb_top import spm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int U = 4;
  logic mclk = 0, rst_n = 0, clk_en = 1, phy_wr, phy_rd, oob_go = 0, pw;
  logic [1:0] oob_sel = 0, cominit_seen, comwake_seen, oob_seq_end, oob_pattern_d243;
  logic [7:0] cfg_rdata, phy_wdata, phy_rdata, pa, rv;
  logic [5:0] phy_addr;
  logic [1:0][1:0] eq_duration;
  logic [1:0][3:0] spm_field;
  spm_cfg_req_t cfg_req = '0;
  spm_tp_stat_t tp_stat = SPM_TP_RST;
  spm_pm_req_t pm_req;
  int n_mismatch = 0, total_checks = 0, cyc = 0, base = 0, np[6], tf[6];
  logic [7:0] offs [8] = '{8'h69, 8'h6a, 8'h6c, 8'h80, 8'h81, 8'h8c, 8'h7d, 8'h70};
  logic [7:0] rstv [8] = '{8'h00, 8'h20, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] mskv [8] = '{8'hff, 8'h38, 8'h38, 8'h0f, 8'hff, 8'h1f, 8'h00, 8'h00};
  spm_regs #(.UNIT_CYC(U)) dut_u (.mclk, .rst_n, .clk_en, .cfg_req, .cfg_rdata, .phy_addr,
    .phy_wr, .phy_rd, .phy_wdata, .phy_rdata, .tp_stat, .cominit_seen, .comwake_seen,
    .oob_seq_end, .eq_duration, .oob_pattern_d243, .pm_req, .spm_field);
  spm_dev_model dev_u (.mclk, .phy_addr, .phy_wr, .phy_rd, .phy_wdata, .phy_rdata, .oob_go,
    .oob_sel, .cominit_seen, .comwake_seen, .oob_seq_end);
  // ****************
  // Helpers
  // ****************
  initial forever #5 mclk = ~mclk;
  // Pulse log: index 0/1 wake, 2/3 slumber, 4/5 partial, odd = port 1
  always @(posedge mclk) begin
    for (int i = 0; i < 6; i++) begin
      if (pm_req[i] === 1'b1) begin
        if (np[i] == 0) tf[i] = cyc - base;
        np[i]++;
      end
    end
    cyc++;
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    cfg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    #1 pa = {2'h0, phy_addr};
    pw = phy_wr;
    @(posedge mclk);
    cfg_req.wr <= 1'b0;
  endtask
  task automatic rdchk(string nm, logic [7:0] a, logic [7:0] e);
    @(posedge mclk);
    cfg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge mclk);
    cfg_req.rd <= 1'b0;
    #1 rv = cfg_rdata;
    chk(nm, e, rv);
  endtask
  task automatic clr();
    #1 np = '{default: 0};
    tf = '{default: 0};
    base = cyc;
  endtask
  // Exactly one pulse since the last clear, and on the named line
  task automatic pchk(string nm, int i);
    chk(nm, 8'h01, 8'(np[i]));
    chk(nm, 8'h01, 8'(np.sum()));
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog: the run needs well under 3000 cycles
  initial begin
    #100us;
    n_mismatch++;
    end_sim();
  end
  // Main sequence
  initial begin
    logic [7:0] d;
    logic [10:0] t;
    void'($urandom(9));
    repeat (5) @(posedge mclk);
    chk("eq_rst", 8'h02, {6'h0, eq_duration[1]});
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk("rst", offs[i], rstv[i]);
    rdchk("ts1_rst", 8'h78, 8'h01);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(offs[i], d);
      rdchk("rw", offs[i], d & mskv[i]);
      if (i == 1 || i == 2) chk("eq", {6'h0, d[5:4]}, {6'h0, eq_duration[i-1]});
      if (i == 1 || i == 2) chk("pat", {7'h0, d[3]}, {7'h0, oob_pattern_d243[i-1]});
    end
    $display("test registers done");
    for (int n = 0; n < 16; n++) begin
      d = 8'($urandom);
      wr(8'h69, {n[3:0], 4'(15 - n)});
      chk("pw_off", 8'h00, {7'h0, pw});
      wr(8'h66, d);
      chk("pa2", 8'(4 * (15 - n) + 2), pa);
      wr(8'h67, ~d);
      chk("pa3", 8'(4 * n + 3), pa);
      chk("pw", 8'h01, {7'h0, pw});
      rdchk("win2", 8'h66, d);
      rdchk("win3", 8'h67, ~d);
    end
    @(posedge mclk) clk_en <= 1'b0;
    wr(8'h69, 8'h55);
    @(posedge mclk) clk_en <= 1'b1;
    rdchk("cken", 8'h69, 8'hf0);
    $display("test windows done");
    for (int k = 0; k < 8; k++) begin
      t = 11'($urandom) & 11'h7df;
      @(posedge mclk) tp_stat <= t;
      rdchk("ts1", 8'h78, {3'h0, t[10:6]});
      rdchk("ts2", 8'h79, {3'h0, t[4:0]});
    end
    @(posedge mclk) tp_stat.pmp_err <= 1'b1;
    @(posedge mclk) tp_stat.pmp_err <= 1'b0;
    rdchk("pmp", 8'h79, {3'h4, t[4:0]});
    wr(8'h79, 8'h7f);
    rdchk("pmp_hold", 8'h79, {3'h4, t[4:0]});
    wr(8'h79, 8'h80);
    rdchk("pmp_clr", 8'h79, {3'h0, t[4:0]});
    $display("test status done");
    for (int s = 0; s < 4; s++) begin
      @(posedge mclk) begin
        oob_sel <= 2'(s);
        oob_go <= 1'b1;
      end
      @(posedge mclk) oob_go <= 1'b0;
      repeat (8) @(posedge mclk);
      rdchk("oob", 8'h7d, 8'(1 << s));
      repeat (16) @(posedge mclk);
      rdchk("oob_end", 8'h7d, 8'h00);
    end
    $display("test oob done");
    @(posedge mclk) tp_stat <= SPM_TP_RST;
    wr(8'h81, 8'h18);
    wr(8'h8c, 8'h18);
    wr(8'h80, 8'h00);
    for (int b = 0; b < 4; b++) begin
      clr();
      wr(8'h80, 8'(1 << b));
      wr(8'h80, 8'(1 << b));
      repeat (2) @(posedge mclk);
      pchk("swpm", (b % 2 == 1 ? 2 : 4) + b / 2);
      chk("fld", b % 2 == 1 ? 8'h02 : 8'h01, {4'h0, spm_field[b/2]});
    end
    wr(8'h81, 8'hd8);
    clr();
    @(posedge mclk) tp_stat.port_sel <= 1'b1;
    repeat (6) @(posedge mclk);
    pchk("switch0", 2);
    wr(8'h81, 8'h98);
    clr();
    @(posedge mclk) tp_stat.port_sel <= 1'b0;
    repeat (6) @(posedge mclk);
    pchk("switch1", 5);
    $display("test power requests done");
    for (int e = 0; e < 4; e++) begin
      @(posedge mclk) tp_stat.dma_rx <= 1'b1;
      wr(8'h81, 8'((e << 3) | 1));
      @(posedge mclk) tp_stat.dma_rx <= 1'b0;
      repeat (2) @(posedge mclk);
      clr();
      repeat (100) @(posedge mclk);
      chk("tpart", 8'(e < 2), 8'(np[4]));
      chk("tslum", 8'(e % 2 == 0), 8'(np[2]));
      chk("twake", 8'(e == 0), 8'(np[0]));
      if (e == 0) chk("tgap", 8'd64, 8'(tf[0] - tf[4]));
      if (e == 0) chk("tseq", 8'd1, 8'(tf[2] - tf[0]));
      if (e == 1) chk("tp_at", 8'h01, 8'(tf[4] >= 12 && tf[4] <= 22));
      if (e == 2) chk("ts_at", 8'h01, 8'(tf[2] >= 76 && tf[2] <= 88));
    end
    $display("test idle timer done");
    end_sim();
  end
endmodule
`default_nettype wire
